//--- core/asi_pkg.sv
// Package for the serial audio interface block: register map, field
// positions, reset values and format codes.
// Assumes an APB master with 32-bit data and byte addressing.
package asi_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ASI_IDX_CTRL0 = 8'h07;
  localparam logic [7:0] ASI_ADDR_CTRL0 = ASI_IDX_CTRL0 << 2;
  localparam logic [7:0] ASI_ADDR_CLKCFG = 8'h40;
  localparam logic [7:0] ASI_ADDR_CAP_L = 8'h44;
  localparam logic [7:0] ASI_ADDR_CAP_R = 8'h48;
  localparam logic [7:0] ASI_ADDR_PLAY_L = 8'h4C;
  localparam logic [7:0] ASI_ADDR_PLAY_R = 8'h50;
  localparam logic [7:0] ASI_ADDR_STATUS = 8'h54;

  // ---------------------------------------------------------------
  // Control register 0 fields
  // ---------------------------------------------------------------
  localparam int unsigned ASI_BIT_PLAY_MUX = 12;
  localparam int unsigned ASI_BIT_PLAY_SLOT = 11;
  localparam int unsigned ASI_BIT_CAP_MUX = 10;
  localparam int unsigned ASI_BIT_CAP_SLOT = 9;
  localparam int unsigned ASI_BIT_MASTER = 6;
  localparam int unsigned ASI_BIT_FRAME_POL = 4;
  localparam int unsigned ASI_POS_WL = 2;
  localparam int unsigned ASI_POS_FMT = 0;
  localparam logic [15:0] ASI_CTRL0_MASK = 16'h1E5F;
  localparam logic [15:0] ASI_CTRL0_RST = 16'h000A;

  // Own clock configuration register fields
  localparam int unsigned ASI_BIT_ENABLE = 0;
  localparam int unsigned ASI_POS_DIV = 4;
  localparam int unsigned ASI_POS_HALF = 16;
  localparam logic [3:0] ASI_DIV_RST = 4'h1;
  localparam logic [8:0] ASI_HALF_RST = 9'h020;

  // ---------------------------------------------------------------
  // Codes and sizes
  // ---------------------------------------------------------------
  localparam logic [1:0] ASI_FMT_RJ = 2'h0;
  localparam logic [1:0] ASI_FMT_LJ = 2'h1;
  localparam logic [1:0] ASI_FMT_I2S = 2'h2;
  localparam logic [1:0] ASI_FMT_DSP = 2'h3;
  localparam logic [5:0] ASI_WL16 = 6'h10;
  localparam logic [5:0] ASI_WL20 = 6'h14;
  localparam logic [5:0] ASI_WL24 = 6'h18;
  localparam logic [5:0] ASI_WL32 = 6'h20;
  localparam logic [5:0] ASI_SAMPLE_W = 6'h18;

  typedef struct packed {
    logic play_mux;
    logic play_slot;
    logic cap_mux;
    logic cap_slot;
    logic master;
    logic frame_pol;
    logic [1:0] wl;
    logic [1:0] fmt;
  } asi_ctrl_t;

endpackage : asi_pkg

//--- core/asi_top.sv
// Serial audio interface: APB register slave, bit/frame clock master or
// slave, four framing formats and two-slot multiplexing per direction.
// Assumes the bit clock is at most a quarter of clk_sys.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module asi_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clock_in,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  input wire logic playback_data_in,
  output logic capture_data_out,
  output logic capture_data_oe
);

  // ---------------------------------------------------------------
  // Slot locator: {valid, dsp right channel, bit index within word}
  // ---------------------------------------------------------------
  function automatic logic [7:0] asi_locate(input logic [11:0] pos,
                                            input logic [11:0] base,
                                            input logic slot,
                                            input logic tdm,
                                            input logic [5:0] wl,
                                            input logic dsp);
    logic [11:0] rel;
    logic [11:0] span;
    logic [11:0] r;
    logic [11:0] lo;
    logic ok;
    logic right;
    rel = pos - base;
    ok = (pos >= base);
    span = tdm ? {5'h00, wl, 1'b0} : {6'h00, wl};
    right = 1'b0;
    r = rel;
    if (dsp && (rel >= span)) begin
      right = 1'b1;
      r = rel - span;
    end
    lo = (tdm && slot) ? {6'h00, wl} : 12'h000;
    ok = ok && (r >= lo) && (r < lo + {6'h00, wl});
    r = r - lo;
    return {ok, right, r[5:0]};
  endfunction : asi_locate

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [15:0] ctrl0;
  logic enable;
  logic [3:0] half_div;
  logic [8:0] frame_half;
  logic [23:0] cap_left;
  logic [23:0] cap_right;
  logic [23:0] play_left;
  logic [23:0] play_right;
  logic [15:0] rx_words;
  logic [11:0] half_len;

  asi_pkg::asi_ctrl_t cfg;
  assign cfg = '{
    play_mux: ctrl0[asi_pkg::ASI_BIT_PLAY_MUX],
    play_slot: ctrl0[asi_pkg::ASI_BIT_PLAY_SLOT],
    cap_mux: ctrl0[asi_pkg::ASI_BIT_CAP_MUX],
    cap_slot: ctrl0[asi_pkg::ASI_BIT_CAP_SLOT],
    master: ctrl0[asi_pkg::ASI_BIT_MASTER],
    frame_pol: ctrl0[asi_pkg::ASI_BIT_FRAME_POL],
    wl: ctrl0[asi_pkg::ASI_POS_WL +: 2],
    fmt: ctrl0[asi_pkg::ASI_POS_FMT +: 2]
  };

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire access_ph = psel && penable;
  wire commit = access_ph && pready;
  wire wr_commit = commit && pwrite;
  wire hit_ctrl0 = (paddr == asi_pkg::ASI_ADDR_CTRL0);
  wire hit_clk = (paddr == asi_pkg::ASI_ADDR_CLKCFG);
  wire hit_cap_l = (paddr == asi_pkg::ASI_ADDR_CAP_L);
  wire hit_cap_r = (paddr == asi_pkg::ASI_ADDR_CAP_R);
  wire hit_play_l = (paddr == asi_pkg::ASI_ADDR_PLAY_L);
  wire hit_play_r = (paddr == asi_pkg::ASI_ADDR_PLAY_R);
  wire hit_stat = (paddr == asi_pkg::ASI_ADDR_STATUS);
  wire hit_any = hit_ctrl0 | hit_clk | hit_cap_l | hit_cap_r | hit_play_l | hit_play_r
                 | hit_stat;
  wire [31:0] clk_word = {7'h00, frame_half, 8'h00, half_div, 3'h0, enable};
  wire [31:0] rd_mux = hit_ctrl0 ? {16'h0000, ctrl0} :
                       hit_clk ? clk_word :
                       hit_cap_l ? {8'h00, cap_left} :
                       hit_cap_r ? {8'h00, cap_right} :
                       hit_play_l ? {8'h00, play_left} :
                       hit_play_r ? {8'h00, play_right} :
                       hit_stat ? {4'h0, half_len, rx_words} : 32'h00000000;

  // One wait state: answer registered so every bus output is a flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= access_ph && !pready;
      prdata <= (access_ph && !pready && !pwrite) ? rd_mux : 32'h00000000;
      pslverr <= access_ph && !pready && !hit_any;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl0 <= asi_pkg::ASI_CTRL0_RST;
      enable <= 1'b0;
      half_div <= asi_pkg::ASI_DIV_RST;
      frame_half <= asi_pkg::ASI_HALF_RST;
      cap_left <= 24'h000000;
      cap_right <= 24'h000000;
    end else if (wr_commit) begin
      if (hit_ctrl0) begin
        ctrl0 <= pwdata[15:0] & asi_pkg::ASI_CTRL0_MASK;
      end
      if (hit_clk) begin
        enable <= pwdata[asi_pkg::ASI_BIT_ENABLE];
        half_div <= pwdata[asi_pkg::ASI_POS_DIV +: 4];
        frame_half <= pwdata[asi_pkg::ASI_POS_HALF +: 9];
      end
      if (hit_cap_l) begin
        cap_left <= pwdata[23:0];
      end
      if (hit_cap_r) begin
        cap_right <= pwdata[23:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic bclk_s1;
  logic bclk_s2;
  logic bclk_s3;
  logic frame_s1;
  logic frame_s2;
  logic din_s1;
  logic din_s2;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      bclk_s1 <= bit_clock_in;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      frame_s1 <= frame_clock_in;
      frame_s2 <= frame_s1;
      din_s1 <= playback_data_in;
      din_s2 <= din_s1;
    end
  end

  // ---------------------------------------------------------------
  // Master bit clock divider and frame generator
  // ---------------------------------------------------------------
  logic [3:0] div_cnt;
  logic [9:0] fcnt;
  wire is_master = cfg.master && enable;
  wire is_dsp = (cfg.fmt == asi_pkg::ASI_FMT_DSP);
  wire div_tc = (div_cnt == half_div);
  wire m_rise = is_master && div_tc && !bit_clock_out;
  wire m_fall = is_master && div_tc && bit_clock_out;
  wire [9:0] frame_len = {frame_half, 1'b0};
  wire [9:0] fcnt_next = (fcnt >= frame_len - 10'h001) ? 10'h000 : fcnt + 10'h001;
  wire second_half = (fcnt_next >= {1'b0, frame_half});
  wire gen_lvl = (cfg.fmt == asi_pkg::ASI_FMT_I2S) ? second_half : !second_half;
  wire gen_frame = is_dsp ? (fcnt_next == 10'h000) : (gen_lvl ^ cfg.frame_pol);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !is_master) begin
      div_cnt <= 4'h0;
      bit_clock_out <= 1'b0;
      fcnt <= 10'h000;
      frame_clock_out <= 1'b0;
    end else begin
      div_cnt <= div_tc ? 4'h0 : div_cnt + 4'h1;
      if (div_tc) begin
        bit_clock_out <= !bit_clock_out;
      end
      if (m_fall) begin
        fcnt <= fcnt_next;
        frame_clock_out <= gen_frame;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bit_clock_oe <= 1'b0;
      frame_clock_oe <= 1'b0;
    end else begin
      bit_clock_oe <= is_master;
      frame_clock_oe <= is_master;
    end
  end

  // ---------------------------------------------------------------
  // Common bit timing: positions counted on falls, data taken on rises
  // ---------------------------------------------------------------
  wire b_rise = enable && (is_master ? m_rise : (bclk_s2 && !bclk_s3));
  wire b_fall = enable && (is_master ? m_fall : (!bclk_s2 && bclk_s3));
  // Slave frame is already synced to the same depth as the bit clock
  wire frame_now = is_master ? gen_frame : frame_s2;
  logic frame_prev;
  logic [11:0] pos;
  logic chan_right;
  wire frame_edge = is_dsp ? (frame_now && !frame_prev) : (frame_now != frame_prev);
  wire [11:0] pos_next = frame_edge ? 12'h000 : pos + 12'h001;
  wire lvl_right = (cfg.fmt == asi_pkg::ASI_FMT_I2S) ? (frame_now ^ cfg.frame_pol)
                                                     : !(frame_now ^ cfg.frame_pol);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !enable) begin
      frame_prev <= 1'b0;
      pos <= 12'h000;
      chan_right <= 1'b0;
      half_len <= 12'h000;
    end else if (b_fall) begin
      frame_prev <= frame_now;
      pos <= pos_next;
      chan_right <= lvl_right;
      if (frame_edge) begin
        half_len <= pos + 12'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Word placement per direction
  // ---------------------------------------------------------------
  wire [5:0] wl_bits = (cfg.wl == 2'h0) ? asi_pkg::ASI_WL16 :
                       (cfg.wl == 2'h1) ? asi_pkg::ASI_WL20 :
                       (cfg.wl == 2'h2) ? asi_pkg::ASI_WL24 : asi_pkg::ASI_WL32;
  wire [11:0] span_tx = cfg.cap_mux ? {5'h00, wl_bits, 1'b0} : {6'h00, wl_bits};
  wire [11:0] span_rx = cfg.play_mux ? {5'h00, wl_bits, 1'b0} : {6'h00, wl_bits};
  wire [11:0] dsp_base = cfg.frame_pol ? 12'h000 : 12'h001;
  // Right justified words end on the last rise of the measured half
  wire [11:0] rj_tx = (half_len >= span_tx) ? half_len - span_tx : 12'hFFF;
  wire [11:0] rj_rx = (half_len >= span_rx) ? half_len - span_rx : 12'hFFF;
  wire [11:0] base_tx = (cfg.fmt == asi_pkg::ASI_FMT_RJ) ? rj_tx :
                        (cfg.fmt == asi_pkg::ASI_FMT_LJ) ? 12'h000 :
                        (cfg.fmt == asi_pkg::ASI_FMT_I2S) ? 12'h001 : dsp_base;
  wire [11:0] base_rx = (cfg.fmt == asi_pkg::ASI_FMT_RJ) ? rj_rx :
                        (cfg.fmt == asi_pkg::ASI_FMT_LJ) ? 12'h000 :
                        (cfg.fmt == asi_pkg::ASI_FMT_I2S) ? 12'h001 : dsp_base;
  wire [7:0] loc_tx = asi_locate(pos_next, base_tx, cfg.cap_slot, cfg.cap_mux, wl_bits,
                                 is_dsp);
  wire [7:0] loc_rx = asi_locate(pos, base_rx, cfg.play_slot, cfg.play_mux, wl_bits,
                                 is_dsp);
  wire tx_valid = loc_tx[7];
  wire [5:0] tx_k = loc_tx[5:0];
  wire tx_right = is_dsp ? loc_tx[6] : lvl_right;
  wire rx_valid = loc_rx[7];
  wire [5:0] rx_k = loc_rx[5:0];
  wire rx_right = is_dsp ? loc_rx[6] : chan_right;

  // ---------------------------------------------------------------
  // Capture transmitter: new bit on each fall, MSB first
  // ---------------------------------------------------------------
  wire tx_real = tx_valid && (tx_k < asi_pkg::ASI_SAMPLE_W);
  wire [5:0] tx_sel6 = asi_pkg::ASI_SAMPLE_W - 6'h01 - tx_k;
  wire [23:0] tx_word = tx_right ? cap_right : cap_left;
  wire tx_bit = tx_real ? tx_word[tx_sel6[4:0]] : 1'b0;
  // Outside a word the line is driven low unless it is shared
  wire tx_drive = tx_real || (!cfg.cap_mux && !tx_valid);

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !enable) begin
      capture_data_out <= 1'b0;
      capture_data_oe <= 1'b0;
    end else if (b_fall) begin
      capture_data_out <= tx_bit;
      capture_data_oe <= tx_drive;
    end
  end

  // ---------------------------------------------------------------
  // Playback receiver: bits taken on rises, word stored on its last bit
  // ---------------------------------------------------------------
  logic [23:0] rx_acc;
  wire rx_real = rx_valid && (rx_k < asi_pkg::ASI_SAMPLE_W);
  wire [5:0] rx_sel6 = asi_pkg::ASI_SAMPLE_W - 6'h01 - rx_k;
  wire [23:0] rx_base = (rx_k == 6'h00) ? 24'h000000 : rx_acc;
  wire [23:0] rx_bitmask = 24'h000001 << rx_sel6[4:0];
  wire [23:0] next_rx_acc = rx_real ? ((rx_base & ~rx_bitmask) | (din_s2 ? rx_bitmask : 24'h0))
                                    : rx_acc;
  wire rx_last = rx_valid && (rx_k == wl_bits - 6'h01);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_acc <= 24'h000000;
      play_left <= 24'h000000;
      play_right <= 24'h000000;
      rx_words <= 16'h0000;
    end else if (b_rise) begin
      rx_acc <= next_rx_acc;
      if (rx_last && rx_right) begin
        play_right <= next_rx_acc;
      end
      if (rx_last && !rx_right) begin
        play_left <= next_rx_acc;
      end
      if (rx_last) begin
        rx_words <= rx_words + 16'h0001;
      end
    end
  end

endmodule : asi_top

//--- bench/asi_props.sv
// Checker for the serial audio interface ports: bus handshake, clock
// ownership and capture line timing.
// Assumes one clk_sys domain and binding to asi_top.
`timescale 1ns/1ns
module asi_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bit_clock_out,
  input wire logic bit_clock_oe,
  input wire logic frame_clock_out,
  input wire logic frame_clock_oe,
  input wire logic capture_data_out,
  input wire logic capture_data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  ctrl_mapped_a: assert property (
    pready && paddr == asi_pkg::ASI_ADDR_CTRL0 |-> !pslverr)
    else $error("control register answered with error");
  clock_owner_a: assert property (frame_clock_oe == bit_clock_oe)
    else $error("clock enables differ");
  clock_idle_a: assert property (!bit_clock_oe |-> !bit_clock_out)
    else $error("bit clock driven high while not master");
  half_period_a: assert property (
    $rose(bit_clock_out) && bit_clock_oe |=> bit_clock_out || !bit_clock_oe)
    else $error("bit clock high phase shorter than two cycles");
  frame_on_fall_a: assert property (
    bit_clock_oe && $past(bit_clock_oe) && $changed(frame_clock_out) |-> $fell(bit_clock_out))
    else $error("frame clock moved off a bit clock fall");
  cap_on_fall_a: assert property (
    bit_clock_oe && $past(bit_clock_oe)
    && ($changed(capture_data_out) || $changed(capture_data_oe)) |-> $fell(bit_clock_out))
    else $error("capture line moved off a bit clock fall");

  cover property (pslverr);
  cover property (capture_data_oe && bit_clock_oe);
  cover property ($fell(capture_data_oe) && bit_clock_oe);
endmodule : asi_props

bind asi_top asi_props asi_props_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe),
  .frame_clock_out(frame_clock_out), .frame_clock_oe(frame_clock_oe),
  .capture_data_out(capture_data_out), .capture_data_oe(capture_data_oe));

//--- bench/asi_far_end.sv
// Far-side I2S master model: makes bit and frame clocks and sends one
// stereo pair of 24-bit words per frame, 32 bit clocks per half.
// Assumes clk_sys; bit clock is clk_sys/8 and stands low while idle.
`timescale 1ns/1ns
module asi_far_end (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [23:0] left_word,
  input wire logic [23:0] right_word,
  output logic bit_clock,
  output logic frame_clock,
  output logic data
);
  logic [2:0] phase;
  logic [5:0] pos;
  logic [5:0] next_pos;
  logic [23:0] word;
  logic in_word;
  assign next_pos = pos + 6'h01;
  assign word = next_pos[5] ? right_word : left_word;
  // I2S: word starts one bit after the frame edge
  assign in_word = next_pos[4:0] >= 5'h01 && next_pos[4:0] <= 5'h18;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase <= 3'h0;
      pos <= 6'h3F;
      bit_clock <= 1'b0;
      frame_clock <= 1'b1;
      data <= 1'b0;
    end else if (!run) begin
      data <= ~data; // Released line toggles so no stale bit passes
    end else begin
      phase <= phase + 3'h1;
      if (phase == 3'h3) begin
        bit_clock <= 1'b1;
      end
      if (phase == 3'h7) begin
        bit_clock <= 1'b0;
        pos <= next_pos;
        frame_clock <= next_pos[5]; // 50 percent frame, well apart
        data <= in_word ? word[5'h18 - next_pos[4:0]] : ~data;
      end
    end
  end
endmodule : asi_far_end

//--- bench/asi_top_test.sv
// Testbench for the serial audio interface: registers, master framing,
// multiplexed capture and slave playback.
// Assumes asi_pkg, asi_top, asi_far_end and asi_props compiled first.
`timescale 1ns/1ns
module asi_top_test;
  logic clk_sys, rst_n, psel, penable, pwrite, far_run, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic bit_clock_out, bit_clock_oe, frame_clock_out, frame_clock_oe;
  logic capture_data_out, capture_data_oe, far_bclk, far_frame, far_data, bclk_q, frm_q;
  logic [31:0] got_oe, got_dat, snap_oe, snap_dat;
  int pos, frames, num_errors, total_checks;
  wire logic bclk_pin = bit_clock_oe ? bit_clock_out : far_bclk;
  wire logic frame_pin = frame_clock_oe ? frame_clock_out : far_frame;
  // Rows: control, enable mask, expected enables, expected data
  localparam logic [31:0] ROWS [8][4] = '{
    '{32'h40, 32'h0000FFFF, 32'h0000FFFF, 32'h0000A5C3},
    '{32'h41, 32'hFFFF0000, 32'hFFFF0000, 32'hA5C30000},
    '{32'h641, 32'hFFFFFFFF, 32'h0000FFFF, 32'h0000A5C3},
    '{32'h44D, 32'hFFFFFFFF, 32'hFFFFFF00, 32'hA5C3F000},
    '{32'h53, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hA5C30F1E},
    '{32'h47, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h52E1F878},
    '{32'h51, 32'hFFFF0000, 32'hFFFF0000, 32'h0F1E0000},
    '{32'h442, 32'hFFFFFFFF, 32'h7FFF8000, 32'h078F0000}};

  asi_top asi_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bit_clock_in(bclk_pin), .bit_clock_out(bit_clock_out),
    .bit_clock_oe(bit_clock_oe), .frame_clock_in(frame_pin),
    .frame_clock_out(frame_clock_out), .frame_clock_oe(frame_clock_oe),
    .playback_data_in(far_data), .capture_data_out(capture_data_out),
    .capture_data_oe(capture_data_oe));
  asi_far_end asi_far_end_i (.clk_sys(clk_sys), .rst_n(rst_n), .run(far_run),
    .left_word(24'h5A3C96), .right_word(24'h123456), .bit_clock(far_bclk),
    .frame_clock(far_frame), .data(far_data));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Position 0 is the first master bit clock rise after a frame rise
  always @(posedge clk_sys) begin
    bclk_q <= bit_clock_out;
    if (bit_clock_oe && bit_clock_out && !bclk_q) begin
      frm_q <= frame_clock_out;
      if (frame_clock_out && !frm_q) begin
        pos = 0;
        frames++;
        snap_oe <= got_oe;
        snap_dat <= got_dat;
      end else begin
        pos++;
      end
      if (pos < 32) begin
        got_oe[31 - pos] <= capture_data_oe;
        got_dat[31 - pos] <= capture_data_out;
      end
    end
  end

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic timed_out;
    num_errors++;
    $display("BAD %0t: wait ran out", $time);
    stop_test();
  endtask : timed_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) timed_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic test_regs;
    apb(1'b0, asi_pkg::ASI_ADDR_CTRL0, 32'h0);
    check(rd, 32'h0000000A, "control reset");
    apb(1'b0, asi_pkg::ASI_ADDR_CLKCFG, 32'h0);
    check(rd, 32'h00200010, "clock config reset");
    apb(1'b1, asi_pkg::ASI_ADDR_CTRL0, 32'hFFFFFFFF);
    apb(1'b0, asi_pkg::ASI_ADDR_CTRL0, 32'h0);
    check(rd, 32'h00001E5F, "control fields");
    apb(1'b0, 8'h3C, 32'h0);
    check({err, rd[30:0]}, 32'h80000000, "unmapped read");
    $display("test_regs done");
  endtask : test_regs

  task automatic test_master;
    int n;
    int f0;
    apb(1'b1, asi_pkg::ASI_ADDR_CAP_L, 32'h00A5C3F0);
    apb(1'b1, asi_pkg::ASI_ADDR_CAP_R, 32'h000F1E2D);
    apb(1'b1, asi_pkg::ASI_ADDR_CLKCFG, 32'h00200011);
    foreach (ROWS[i]) begin
      apb(1'b1, asi_pkg::ASI_ADDR_CTRL0, ROWS[i][0]);
      f0 = frames;
      for (n = 0; n < 3000 && frames < f0 + 3; n++) @(posedge clk_sys);
      if (n == 3000) timed_out();
      // Let the snapshot of a whole frame under the new setting settle
      @(posedge clk_sys);
      check(snap_oe & ROWS[i][1], ROWS[i][2], "capture enable");
      check(snap_dat & ROWS[i][2], ROWS[i][3], "capture data");
    end
    check({31'h0, bit_clock_oe}, 32'h1, "master drives clocks");
    $display("test_master done");
  endtask : test_master

  task automatic poll(input logic [7:0] addr, input logic [31:0] exp, input string what);
    int n;
    for (n = 0; n < 400; n++) begin
      apb(1'b0, addr, 32'h0);
      if (rd === exp) break;
    end
    check(rd, exp, what);
  endtask : poll

  task automatic test_slave;
    apb(1'b1, asi_pkg::ASI_ADDR_CTRL0, 32'h0000000A);
    far_run <= 1'b1;
    poll(asi_pkg::ASI_ADDR_PLAY_L, 32'h005A3C96, "playback left");
    poll(asi_pkg::ASI_ADDR_PLAY_R, 32'h00123456, "playback right");
    check({31'h0, bit_clock_oe}, 32'h0, "slave leaves clocks");
    $display("test_slave done");
  endtask : test_slave

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    far_run = 1'b0;
    bclk_q = 1'b0;
    frm_q = 1'b0;
    pos = 0;
    frames = 0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    test_regs();
    test_master();
    test_slave();
    stop_test();
  end
endmodule : asi_top_test
